// [rxdc_cfg_ram.sv]
// Receive DMA per-channel configuration store with indirect host access
`timescale 1ns/1ps
`default_nettype none

module rxdc_cfg_ram (
	// Clock and reset
	input wire logic core_clk,
	input wire logic rst_n,
	// Register bus
	input wire logic [rxdc_pkg::ADDR_W-1:0] regAddr,
	input wire logic [15:0] regWrData,
	input wire logic regWrite,
	input wire logic regRead,
	output logic [31:0] regRdData,
	// Receive DMA event port
	input wire logic evtValid,
	input wire rxdc_pkg::rxdc_evt_s evt,
	output logic evtReady,
	// Results toward the DMA engine
	output rxdc_pkg::rxdc_done_s doneReport,
	output logic useLargeBuf,
	output logic chanEnabled
);
	import rxdc_pkg::*;

	typedef enum logic [2:0] {
		ST_IDLE,
		ST_FETCH,
		ST_HOST_FETCH,
		ST_HOST,
		ST_DMA
	} rxdc_state_e;

	// Store array, one 32-bit dword per entry
	logic [31:0] store [STORE_DEPTH];
	logic [31:0] storeQ;

	// Control state
	rxdc_state_e state_q, state_d;
	logic [7:0] selChan_q, selChan_d;
	logic [2:0] selWord_q, selWord_d;
	logic selRw_q, selRw_d;
	logic busy_q, busy_d;
	logic hostPend_q, hostPend_d;
	logic [15:0] dataReg_q, dataReg_d;
	logic [STORE_AW-1:0] opAddr_q, opAddr_d;
	rxdc_evt_s evt_q, evt_d;
	logic [31:0] rdData_q, rdData_d;
	logic evtReady_q, evtReady_d;
	rxdc_done_s done_q, done_d;
	logic useLarge_q, useLarge_d;
	logic chanEn_q, chanEn_d;

	// Store write port
	logic memWe;
	logic [31:0] memWdata;

	// Decoded bus strobes
	logic selWrite, dataWrite;
	assign selWrite = regWrite && (regAddr == OFS_SELECT);
	assign dataWrite = regWrite && (regAddr == OFS_DATA);

	// Third dword fields of the fetched entry
	logic [1:0] fSize;
	logic [2:0] fThresh, fTcount;
	logic [12:0] fBytes;
	assign fSize = storeQ[DW2_SIZE_LSB +: 2];
	assign fThresh = storeQ[DW2_THRESH_LSB +: 3];
	assign fTcount = storeQ[DW2_TCOUNT_LSB +: 3];
	assign fBytes = storeQ[DW2_BYTES_LSB +: 13];

	// Entry index: channel times three plus dword number
	function automatic logic [STORE_AW-1:0] entryIndex(input logic [7:0] ch,
		input logic [1:0] dw);
		logic [STORE_AW-1:0] base;
		base = {1'b0, ch, 1'b0} + {2'b00, ch};
		return base + {{(STORE_AW-2){1'b0}}, dw};
	endfunction : entryIndex

	// Main sequencer: host accesses and DMA read-modify-write
	always_comb begin
		logic [31:0] upd;
		logic [13:0] sum;
		logic [2:0] cnt;
		logic fbf;
		upd = storeQ;
		sum = 14'h0000;
		cnt = fTcount;
		fbf = storeQ[DW2_FBF_BIT];
		state_d = state_q;
		selChan_d = selChan_q;
		selWord_d = selWord_q;
		selRw_d = selRw_q;
		busy_d = busy_q;
		hostPend_d = hostPend_q;
		dataReg_d = dataReg_q;
		opAddr_d = opAddr_q;
		evt_d = evt_q;
		done_d = '0;
		useLarge_d = useLarge_q;
		chanEn_d = chanEn_q;
		memWe = 1'b0;
		memWdata = storeQ;

		// Bus writes are refused while an indirect access is in flight
		if (dataWrite && !busy_q) begin
			dataReg_d = regWrData;
		end
		if (selWrite && !busy_q) begin
			selChan_d = regWrData[SEL_CHAN_LSB +: 8];
			selWord_d = regWrData[SEL_WSEL_LSB +: 3];
			selRw_d = regWrData[SEL_RW_BIT];
			busy_d = 1'b1;
			hostPend_d = 1'b1;
		end

		unique case (state_q)
			ST_IDLE: begin
				// An event shown ready wins this slot; host goes next
				if (evtValid && evtReady_q) begin
					evt_d = evt;
					if (evt.kind == EV_DW0) begin
						opAddr_d = entryIndex(evt.chan, 2'h0);
					end else if (evt.kind == EV_DW1) begin
						opAddr_d = entryIndex(evt.chan, 2'h1);
					end else begin
						opAddr_d = entryIndex(evt.chan, DWORD_CFG);
					end
					state_d = ST_FETCH;
				end else if (hostPend_q) begin
					opAddr_d = entryIndex(selChan_q, selWord_q[2:1]);
					state_d = ST_HOST_FETCH;
				end
			end
			ST_FETCH: begin
				// DMA entry is read into storeQ at this edge
				state_d = ST_DMA;
			end
			ST_HOST_FETCH: begin
				// Separate host path so a same-edge event is never dropped
				state_d = ST_HOST;
			end
			ST_HOST: begin
				if (selWord_q <= WSEL_LAST_LEGAL) begin
					if (selRw_q) begin
						dataReg_d = selWord_q[0] ? storeQ[31:16] : storeQ[15:0];
					end else begin
						// Whole half taken as given; reserved bits stored too
						memWe = 1'b1;
						memWdata = selWord_q[0] ? {dataReg_q, storeQ[15:0]}
							: {storeQ[31:16], dataReg_q};
					end
				end
				busy_d = 1'b0;
				hostPend_d = 1'b0;
				state_d = ST_IDLE;
			end
			ST_DMA: begin
				unique case (evt_q.kind)
					EV_DW0, EV_DW1: begin
						upd = evt_q.data;
					end
					EV_SOP: begin
						fbf = 1'b1;
						upd[DW2_BYTES_LSB +: 13] = '0;
					end
					EV_BYTES: begin
						sum = {1'b0, fBytes} + {1'b0, evt_q.bytes};
						// Saturate rather than wrap past the buffer ceiling
						if (sum > {1'b0, BYTES_MAX}) begin
							upd[DW2_BYTES_LSB +: 13] = BYTES_MAX;
						end else begin
							upd[DW2_BYTES_LSB +: 13] = sum[12:0];
						end
					end
					EV_BUF_FULL: begin
						cnt = fTcount + 3'h1;
						fbf = 1'b0;
						upd[DW2_BYTES_LSB +: 13] = '0;
						if (fThresh != THRESH_PACKET_ONLY && cnt >= fThresh) begin
							done_d.valid = storeQ[DW2_ENABLE_BIT];
							cnt = 3'h0;
						end
					end
					EV_EOP: begin
						done_d.valid = storeQ[DW2_ENABLE_BIT];
						done_d.endOfPacket = 1'b1;
						cnt = 3'h0;
						fbf = 1'b0;
						upd[DW2_BYTES_LSB +: 13] = '0;
					end
					default: begin
						upd = storeQ;
					end
				endcase
				if (evt_q.kind != EV_DW0 && evt_q.kind != EV_DW1) begin
					upd[DW2_TCOUNT_LSB +: 3] = cnt;
					upd[DW2_FBF_BIT] = fbf;
					chanEn_d = storeQ[DW2_ENABLE_BIT];
					// Mixed mode: small while first buffer fills, then large
					useLarge_d = (fSize == SIZE_LARGE_ONLY) ||
						(fSize == SIZE_SMALL_THEN_LARGE && !fbf);
				end
				done_d.chan = evt_q.chan;
				memWe = 1'b1;
				memWdata = upd;
				state_d = ST_IDLE;
			end
			default: begin
				state_d = ST_IDLE;
			end
		endcase

		// Ready only when the next cycle is free and no host access waits
		evtReady_d = (state_d == ST_IDLE) && !hostPend_d;
	end

	// Register read decode; answer appears one cycle after the strobe
	always_comb begin
		rdData_d = 32'h0000_0000;
		if (regRead) begin
			if (regAddr == OFS_SELECT) begin
				rdData_d[SEL_CHAN_LSB +: 8] = selChan_q;
				rdData_d[SEL_WSEL_LSB +: 3] = selWord_q;
				rdData_d[SEL_RW_BIT] = selRw_q;
				rdData_d[SEL_BUSY_BIT] = busy_q;
			end else if (regAddr == OFS_DATA) begin
				rdData_d[15:0] = dataReg_q;
			end
		end
	end

	// Store array: synchronous read and write, no reset on contents
	always_ff @(posedge core_clk) begin
		storeQ <= store[opAddr_q];
		if (memWe) begin
			store[opAddr_q] <= memWdata;
		end
	end

	// Control registers
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			state_q <= ST_IDLE;
			selChan_q <= SELECT_RESET[SEL_CHAN_LSB +: 8];
			selWord_q <= SELECT_RESET[SEL_WSEL_LSB +: 3];
			selRw_q <= SELECT_RESET[SEL_RW_BIT];
			busy_q <= SELECT_RESET[SEL_BUSY_BIT];
			hostPend_q <= 1'b0;
			dataReg_q <= DATA_RESET;
			opAddr_q <= '0;
			evt_q <= '0;
			rdData_q <= 32'h0000_0000;
			evtReady_q <= 1'b0;
			done_q <= '0;
			useLarge_q <= 1'b0;
			chanEn_q <= 1'b0;
		end else begin
			state_q <= state_d;
			selChan_q <= selChan_d;
			selWord_q <= selWord_d;
			selRw_q <= selRw_d;
			busy_q <= busy_d;
			hostPend_q <= hostPend_d;
			dataReg_q <= dataReg_d;
			opAddr_q <= opAddr_d;
			evt_q <= evt_d;
			rdData_q <= rdData_d;
			evtReady_q <= evtReady_d;
			done_q <= done_d;
			useLarge_q <= useLarge_d;
			chanEn_q <= chanEn_d;
		end
	end

	// Outputs straight from flops
	assign regRdData = rdData_q;
	assign evtReady = evtReady_q;
	assign doneReport = done_q;
	assign useLargeBuf = useLarge_q;
	assign chanEnabled = chanEn_q;

endmodule : rxdc_cfg_ram

`default_nettype wire

// [rxdc_pkg.sv]
// Package for the receive DMA channel configuration store
package rxdc_pkg;

	// Register bus geometry and register byte addresses
	localparam int ADDR_W = 12;
	localparam logic [11:0] OFS_SELECT = 12'h770;
	localparam logic [11:0] OFS_DATA = 12'h774;
	localparam logic [15:0] SELECT_RESET = 16'h0000;
	localparam logic [15:0] DATA_RESET = 16'h0000;

	// Store geometry
	localparam int NUM_CHAN = 256;
	localparam int DWORDS_PER_CHAN = 3;
	localparam int STORE_DEPTH = NUM_CHAN * DWORDS_PER_CHAN;
	localparam int STORE_AW = 10;

	// Select register fields
	localparam int SEL_CHAN_LSB = 0;
	localparam int SEL_WSEL_LSB = 8;
	localparam int SEL_RW_BIT = 14;
	localparam int SEL_BUSY_BIT = 15;

	// Word select codes; 110 and 111 are illegal
	localparam logic [2:0] WSEL_LAST_LEGAL = 3'h5;
	localparam logic [2:0] WSEL_HOST_WRITABLE = 3'h4;

	// Third dword field positions
	localparam int DW2_ENABLE_BIT = 0;
	localparam int DW2_SIZE_LSB = 1;
	localparam int DW2_THRESH_LSB = 7;
	localparam int DW2_FBF_BIT = 15;
	localparam int DW2_BYTES_LSB = 16;
	localparam int DW2_TCOUNT_LSB = 29;
	localparam logic [1:0] DWORD_CFG = 2'h2;

	// Buffer size modes; 11 is illegal
	localparam logic [1:0] SIZE_LARGE_ONLY = 2'h0;
	localparam logic [1:0] SIZE_SMALL_ONLY = 2'h1;
	localparam logic [1:0] SIZE_SMALL_THEN_LARGE = 2'h2;

	// Byte count ceiling and packet-only threshold code
	localparam logic [12:0] BYTES_MAX = 13'h1ffc;
	localparam logic [2:0] THRESH_PACKET_ONLY = 3'h0;

	// Events the receive DMA engine posts to the store
	typedef enum logic [2:0] {
		EV_SOP,
		EV_BYTES,
		EV_BUF_FULL,
		EV_EOP,
		EV_DW0,
		EV_DW1
	} rxdc_kind_e;

	typedef struct packed {
		rxdc_kind_e kind;
		logic [7:0] chan;
		logic [12:0] bytes;
		logic [31:0] data;
	} rxdc_evt_s;

	// Done-queue report toward the descriptor writer
	typedef struct packed {
		logic valid;
		logic [7:0] chan;
		logic endOfPacket;
	} rxdc_done_s;

endpackage : rxdc_pkg

// [rxdc_cfg_ram_chk.sv]
// Port checker for the receive DMA configuration store
`timescale 1ns/1ps
`default_nettype none
module rxdc_cfg_ram_chk (
	// Clock and reset
	input wire logic core_clk,
	input wire logic rst_n,
	// Register bus
	input wire logic [rxdc_pkg::ADDR_W-1:0] regAddr,
	input wire logic [15:0] regWrData,
	input wire logic regWrite,
	input wire logic regRead,
	input wire logic [31:0] regRdData,
	// DMA side
	input wire logic evtValid,
	input wire rxdc_pkg::rxdc_evt_s evt,
	input wire logic evtReady,
	input wire rxdc_pkg::rxdc_done_s doneReport,
	input wire logic useLargeBuf,
	input wire logic chanEnabled
);
	import rxdc_pkg::*;
	default clocking @(posedge core_clk); endclocking
	default disable iff (!rst_n);
	// Helper strobes, kept out of $past arguments
	logic take;
	logic selRd;
	assign take = evtValid && evtReady;
	assign selRd = regRead && regAddr == OFS_SELECT;
	rd_idle_zero_a: assert property (regRdData != 0 |-> $past(regRead))
		else $error("read data outside slot");
	sel_fields_a: assert property ($past(selRd) |-> regRdData[31:16] == 0)
		else $error("select read upper bits set");
	eop_kind_a: assert property (doneReport.valid && doneReport.endOfPacket |->
		$past(take, 3) && $past(evt.kind, 3) == EV_EOP) else $error("packet report without end");
	buf_kind_a: assert property (doneReport.valid && !doneReport.endOfPacket |->
		$past(take, 3) && $past(evt.kind, 3) == EV_BUF_FULL) else $error("stray buffer report");
	done_pulse_a: assert property (doneReport.valid |=> !doneReport.valid)
		else $error("report longer than one cycle");
	done_chan_a: assert property (doneReport.valid |-> doneReport.chan == $past(evt.chan, 3))
		else $error("report channel wrong");
	out_hold_a: assert property (!$past(take, 3) |-> $stable(chanEnabled) && $stable(useLargeBuf))
		else $error("outputs moved without event");
	evt_gap_a: assert property (take |=> !evtReady [*2])
		else $error("event port ready too soon");
endmodule : rxdc_cfg_ram_chk
bind rxdc_cfg_ram rxdc_cfg_ram_chk u_chk (.core_clk(core_clk), .rst_n(rst_n), .regAddr(regAddr),
	.regWrData(regWrData), .regWrite(regWrite), .regRead(regRead), .regRdData(regRdData),
	.evtValid(evtValid), .evt(evt), .evtReady(evtReady), .doneReport(doneReport),
	.useLargeBuf(useLargeBuf), .chanEnabled(chanEnabled));
`default_nettype wire

// [rx_dma_channel_config_ram_tb_top.sv]
// Self-checking bench for the receive DMA configuration store
`timescale 1ns/1ps
`default_nettype none
module rx_dma_channel_config_ram_tb_top;
	import rxdc_pkg::*;
	logic core_clk = 0, rst_n = 0, regWrite = 0, regRead = 0, evtValid = 0;
	logic evtReady, useLargeBuf, chanEnabled;
	logic [11:0] regAddr = 0;
	logic [15:0] regWrData = 0;
	logic [31:0] regRdData, rv;
	rxdc_evt_s evt = '0;
	rxdc_done_s doneReport;
	logic [31:0] m [768];
	int fail_count = 0, comparisons = 0, seed = 86453;
	// Free-running 100 MHz clock
	always #5 core_clk = ~core_clk;
	rxdc_cfg_ram uut (.core_clk(core_clk), .rst_n(rst_n), .regAddr(regAddr),
		.regWrData(regWrData), .regWrite(regWrite), .regRead(regRead), .regRdData(regRdData),
		.evtValid(evtValid), .evt(evt), .evtReady(evtReady), .doneReport(doneReport),
		.useLargeBuf(useLargeBuf), .chanEnabled(chanEnabled));
	task print_verdict;
		$display("comparisons %0d mismatches %0d", comparisons, fail_count);
		if (fail_count == 0 && comparisons > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask : print_verdict
	task chk(input logic [31:0] got, input logic [31:0] exp, input string s);
		comparisons++;
		if (got !== exp) begin
			fail_count++;
			$display("FAIL %0t %s got %h exp %h", $time, s, got, exp);
		end
	endtask : chk
	// Bus cycles: strobes change just after the edge, one cycle long
	task wr(input logic [11:0] a, input logic [15:0] d);
		@(posedge core_clk);
		regAddr <= a;
		regWrData <= d;
		regWrite <= 1;
		@(posedge core_clk);
		regWrite <= 0;
	endtask : wr
	task rd(input logic [11:0] a);
		@(posedge core_clk);
		regAddr <= a;
		regRead <= 1;
		@(posedge core_clk);
		regRead <= 0;
		#1 rv = regRdData;
	endtask : rd
	// Poll busy with a bound so a stuck flag cannot hang the run
	task pollb(input logic [10:0] sel);
		int i;
		i = 0;
		do begin
			rd(OFS_SELECT);
			i++;
		end while (rv[15] !== 1'b0 && i < 20);
		chk({rv[15], rv[10:0]}, {1'b0, sel}, "busy or select");
		if (rv[15] !== 1'b0)
			print_verdict;
	endtask : pollb
	task hr(input logic [7:0] c, input logic [2:0] w);
		wr(OFS_SELECT, {2'h1, 3'h0, w, c});
		pollb({w, c});
		rd(OFS_DATA);
		chk(rv, m[c*3+w/2] >> (w[0]*16) & 32'hffff, "word read");
	endtask : hr
	// One event, then compare the outputs with the model two edges after it is taken
	task ev(input rxdc_kind_e k, input logic [7:0] c, input logic [12:0] n, input logic [31:0] d);
		int i;
		logic [31:0] x;
		logic hit;
		@(posedge core_clk);
		evtValid <= 1;
		evt <= '{k, c, n, d};
		i = 0;
		do begin
			@(negedge core_clk);
			i++;
		end while (evtReady !== 1'b1 && i < 20);
		chk(evtReady, 1, "event refused");
		if (evtReady !== 1'b1)
			print_verdict;
		@(posedge core_clk);
		evtValid <= 0;
		x = m[c*3+2];
		if (k >= EV_DW0)
			m[c*3+(k==EV_DW1)] = d;
		else if (k == EV_BYTES)
			x[28:16] = (x[28:16] + n > 8188) ? 13'h1ffc : x[28:16] + n;
		else begin
			x[15] = k == EV_SOP;
			x[28:16] = 0;
		end
		if (k == EV_BUF_FULL)
			x[31:29] = x[31:29] + 1;
		hit = k == EV_EOP || (k == EV_BUF_FULL && x[9:7] != 0 && x[31:29] >= x[9:7]);
		if (hit)
			x[31:29] = 0;
		if (k < EV_DW0)
			m[c*3+2] = x;
		repeat (2) @(posedge core_clk);
		#1;
		if (k < EV_DW0) begin
			chk({doneReport.valid, doneReport.endOfPacket}, {hit && x[0], k == EV_EOP}, "done");
			chk(useLargeBuf, x[2:1] == 0 || (x[2:1] == 2 && !x[15]), "large buf");
			chk(chanEnabled, x[0], "enable");
		end
	endtask : ev
	initial begin
		logic [7:0] c;
		logic [15:0] v;
		repeat (2) @(posedge core_clk);
		rst_n <= 1;
		rd(OFS_SELECT);
		chk(rv, 0, "select reset");
		rd(12'h778);
		chk(rv, 0, "unmapped");
		$display("test reset done");
		// Every threshold, every legal size mode, one channel disabled
		for (int t = 0; t < 8; t++) begin
			c = t == 0 ? 8'h00 : t == 7 ? 8'hff : 8'($random(seed));
			v = {6'h0, 3'(t), 4'h0, 2'(t % 3), 1'(t != 5)};
			wr(OFS_DATA, v);
			wr(OFS_SELECT, {8'h04, c});
			pollb({3'h4, c});
			m[c*3+2][15:0] = v;
			ev(EV_EOP, c, 0, 0);
			ev(EV_SOP, c, 0, 0);
			ev(EV_BYTES, c, 13'($random(seed)) & 13'hfff, 0);
			ev(EV_BYTES, c, 13'h1ffc, 0);
			hr(c, 5);
			repeat (8) ev(EV_BUF_FULL, c, 0, 0);
			ev(EV_DW0, c, 0, $random(seed));
			ev(EV_DW1, c, 0, $random(seed));
			for (int w = 0; w < 6; w++)
				hr(c, 3'(w));
		end
		$display("test channels done");
		// Illegal word codes: read leaves data, write stores nothing
		hr(0, 4);
		wr(OFS_SELECT, 16'h4600);
		pollb(11'h600);
		rd(OFS_DATA);
		chk(rv, m[2] & 32'hffff, "illegal read");
		wr(OFS_DATA, 16'h0381);
		wr(OFS_SELECT, 16'h0700);
		pollb(11'h700);
		hr(0, 4);
		// Data write while busy must be ignored
		wr(OFS_DATA, 16'h0201);
		wr(OFS_SELECT, 16'h0400);
		wr(OFS_DATA, 16'h0080);
		pollb(11'h400);
		m[2][15:0] = 16'h0201;
		hr(0, 4);
		$display("test refusals done");
		print_verdict;
	end
endmodule : rx_dma_channel_config_ram_tb_top
`default_nettype wire
